// file: logic/pts_timer.sv
// Purpose: 8-bit period timer with prescaler, period match and postscaler
// Assumes: plain register port, read data one cycle after the strobe
// Notes: match pulse and count are exported for serial port and pwm use
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - The count advances on the instruction clock divided by 1, 4 or 16.
// - Prescale field 00 is 1, 01 is 4, 1x is 16.
// - Count runs up from zero to the period value, then wraps to zero.
// - The period register is read/write and resets to all ones.
// - The count is read/write and resets to zero.
// - Matches pass a 4-bit postscaler that sets the flag bit 1.
// - Postscale field in bits 6..3 divides by its value plus one.
// - Control bit 2 runs the timer when one and stops it when zero.
// - Count or control writes and reset clear both scaler counters.
// - A control write leaves the count untouched.
// - The unscaled match pulse goes to the serial port.
// - Count and match are offered as the pwm time base.
// - Control bit 7 reads zero and the other bits reset to zero.
module pts_timer
    import pts_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire pts_bus_type bus,
    output logic [7:0] rdata,
    // interrupt
    output logic irq,
    // time base to serial port and pwm
    output logic ssp_match,
    output var pts_base_type pwm_base
);
    logic [7:0] count_r;
    logic [7:0] period_r;
    pts_ctrl_type ctrl_r;
    logic [3:0] post_r;
    logic flag_r;
    logic enable_r;
    logic [7:0] rdata_r;
    logic tick;
    logic match;
    logic post_done;
    logic wr_count;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_enable;
    logic wr_period;
    logic scaler_clear;

    assign wr_count = bus.wr && bus.addr == PTS_OFS_COUNT;
    assign wr_ctrl = bus.wr && bus.addr == PTS_OFS_CTRL;
    assign wr_flag = bus.wr && bus.addr == PTS_OFS_FLAG;
    assign wr_enable = bus.wr && bus.addr == PTS_OFS_ENABLE;
    assign wr_period = bus.wr && bus.addr == PTS_OFS_PERIOD;
    assign scaler_clear = wr_count || wr_ctrl;

    pts_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(ctrl_r.timer_run),
        .clear(scaler_clear),
        .sel(ctrl_r.prescale_select),
        .tick(tick)
    );

    // match is judged on the increment that wraps the count
    assign match = tick && (count_r == period_r);
    assign post_done = match && (post_r == ctrl_r.postscale_select);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_r <= PTS_RST_COUNT;
        end else if (wr_count) begin
            count_r <= bus.wdata;
        end else if (match) begin
            count_r <= 8'h00;
        end else if (tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            period_r <= PTS_RST_PERIOD;
        end else if (wr_period) begin
            period_r <= bus.wdata;
        end
    end

    // bit 7 is not stored at all, so it always reads zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= PTS_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_r <= bus.wdata[6:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            post_r <= 4'h0;
        end else if (scaler_clear) begin
            post_r <= 4'h0;
        end else if (match) begin
            post_r <= post_done ? 4'h0 : post_r + 4'h1;
        end
    end

    // a completion in the clearing cycle wins over the software clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (post_done) begin
            flag_r <= 1'b1;
        end else if (wr_flag && bus.wdata[PTS_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_r <= 1'b0;
        end else if (wr_enable) begin
            enable_r <= bus.wdata[PTS_FLAG_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                PTS_OFS_FLAG: rdata_r <= {6'h00, flag_r, 1'b0};
                PTS_OFS_COUNT: rdata_r <= count_r;
                PTS_OFS_CTRL: rdata_r <= {1'b0, ctrl_r};
                PTS_OFS_ENABLE: rdata_r <= {6'h00, enable_r, 1'b0};
                PTS_OFS_PERIOD: rdata_r <= period_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign irq = flag_r && enable_r;
    assign ssp_match = match;
    assign pwm_base = '{count: count_r, match: match, tick: tick};

    wrap_to_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        match && !wr_count |=> count_r == 8'h00)
        else $error("count did not wrap after match");
    count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && !match && !wr_count |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not step on tick");
    period_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_period |=> period_r == $past(bus.wdata))
        else $error("period write lost");
    ctrl_keeps_count_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_ctrl && !tick |=> count_r == $past(count_r))
        else $error("control write changed count");
    scaler_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        scaler_clear |=> post_r == 4'h0)
        else $error("postscaler not cleared");
    stopped_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl_r.timer_run && !bus.wr |=> $stable(count_r) && $stable(post_r))
        else $error("state moved while stopped");
    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
        flag_r && !(wr_flag && bus.wdata[PTS_FLAG_BIT]) |=> flag_r)
        else $error("flag dropped without clear");
    flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        post_done |=> flag_r)
        else $error("postscaler completion did not set flag");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        irq == (flag_r && enable_r))
        else $error("irq not gated by enable");
    ctrl_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd && bus.addr == PTS_OFS_CTRL |=> rdata[7] == 1'b0)
        else $error("control bit 7 read as one");

    // checker-only helpers, not used by the timer logic itself
    logic [6:0] tick_len;
    logic [6:0] tick_gap_r;
    logic [8:0] span_r;
    logic span_ok_r;

    // expected cycles per tick, built from the divider constants
    always_comb begin
        case (ctrl_r.prescale_select)
            PTS_PRE_DIV1: tick_len = 7'({4'h0, PTS_ICLK_LAST}) + 7'h01;
            PTS_PRE_DIV4: tick_len = 7'({PTS_PRE_LAST4, PTS_ICLK_LAST}) + 7'h01;
            default: tick_len = 7'({PTS_PRE_LAST16, PTS_ICLK_LAST}) + 7'h01;
        endcase
    end

    // run only changes through a control write, which clears the scalers,
    // so every tick is a full prescale period after the previous event
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_gap_r <= 7'h00;
        end else if (scaler_clear || tick) begin
            tick_gap_r <= 7'h00;
        end else if (ctrl_r.timer_run) begin
            tick_gap_r <= tick_gap_r + 7'h01;
        end
    end

    // ticks between two matches with no count or period write between
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            span_r <= 9'h000;
        end else if (match || wr_count) begin
            span_r <= 9'h000;
        end else if (tick) begin
            span_r <= span_r + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            span_ok_r <= 1'b0;
        end else if (wr_count || wr_period) begin
            span_ok_r <= 1'b0;
        end else if (match) begin
            span_ok_r <= 1'b1;
        end
    end

    tick_spacing_a: assert property (@(posedge clk_sys)
        disable iff (rst) tick |-> tick_gap_r + 7'h01 == tick_len)
        else $error("tick spacing does not follow the prescale");

    tick_gap_bound_a: assert property (@(posedge clk_sys)
        disable iff (rst) tick_gap_r < tick_len)
        else $error("prescale period overrun");

    stopped_no_tick_a: assert property (@(posedge clk_sys)
        disable iff (rst) !ctrl_r.timer_run |-> !tick)
        else $error("tick while stopped");

    match_span_a: assert property (@(posedge clk_sys)
        disable iff (rst) match && span_ok_r |-> span_r == {1'b0, period_r})
        else $error("match period differs from period register");

    count_stay_a: assert property (@(posedge clk_sys)
        disable iff (rst) !tick && !wr_count |=> $stable(count_r))
        else $error("count moved without tick");

    count_write_a: assert property (@(posedge clk_sys)
        disable iff (rst) wr_count |=> count_r == $past(bus.wdata))
        else $error("count write lost");

    count_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        bus.rd && bus.addr == PTS_OFS_COUNT |=> rdata == $past(count_r))
        else $error("count read wrong");

    period_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        bus.rd && bus.addr == PTS_OFS_PERIOD |=> rdata == $past(period_r))
        else $error("period read wrong");

    period_hold_a: assert property (@(posedge clk_sys)
        disable iff (rst) !wr_period |=> $stable(period_r))
        else $error("period changed without write");

    ctrl_write_a: assert property (@(posedge clk_sys)
        disable iff (rst) wr_ctrl |=> ctrl_r == $past(bus.wdata[6:0]))
        else $error("control write lost");

    ctrl_hold_a: assert property (@(posedge clk_sys)
        disable iff (rst) !wr_ctrl |=> $stable(ctrl_r))
        else $error("control changed without write");

    post_step_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        match && !post_done |=> post_r == $past(post_r) + 4'h1)
        else $error("postscaler did not count the match");

    post_wrap_a: assert property (@(posedge clk_sys)
        disable iff (rst) post_done |=> post_r == 4'h0)
        else $error("postscaler did not restart");

    post_bound_a: assert property (@(posedge clk_sys)
        disable iff (rst) post_r <= ctrl_r.postscale_select)
        else $error("postscaler passed its select value");

    post_hold_a: assert property (@(posedge clk_sys)
        disable iff (rst) !match && !scaler_clear |=> $stable(post_r))
        else $error("postscaler moved without match");

    flag_cause_a: assert property (@(posedge clk_sys)
        disable iff (rst) $rose(flag_r) |-> $past(post_done))
        else $error("flag set without postscaler completion");

    flag_read_a: assert property (@(posedge clk_sys)
        disable iff (rst) bus.rd && bus.addr == PTS_OFS_FLAG
        |=> rdata == {6'h00, $past(flag_r), 1'b0})
        else $error("flag read wrong");

    flag_clear_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        wr_flag && bus.wdata[PTS_FLAG_BIT] && !post_done |=> !flag_r)
        else $error("flag clear ignored");

    enable_write_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        wr_enable |=> enable_r == $past(bus.wdata[PTS_FLAG_BIT]))
        else $error("enable write lost");

    enable_read_a: assert property (@(posedge clk_sys)
        disable iff (rst) bus.rd && bus.addr == PTS_OFS_ENABLE
        |=> rdata == {6'h00, $past(enable_r), 1'b0})
        else $error("enable read wrong");

    irq_rise_a: assert property (@(posedge clk_sys)
        disable iff (rst) $rose(flag_r) && enable_r |-> irq)
        else $error("enabled flag gave no irq");

    ssp_pulse_a: assert property (@(posedge clk_sys)
        disable iff (rst) ssp_match |=> !ssp_match)
        else $error("serial port match longer than one cycle");

    pwm_tick_a: assert property (@(posedge clk_sys)
        disable iff (rst) pwm_base.match |-> pwm_base.tick)
        else $error("pwm match without tick");

    match_seen_c: cover property (@(posedge clk_sys) disable iff (rst) match);
    flag_set_c: cover property (@(posedge clk_sys) disable iff (rst)
        post_done && ctrl_r.postscale_select == 4'hf);
    irq_c: cover property (@(posedge clk_sys) disable iff (rst) irq);
    div16_tick_c: cover property (@(posedge clk_sys) disable iff (rst)
        tick && ctrl_r.prescale_select[1]);
    set_vs_clear_c: cover property (@(posedge clk_sys) disable iff (rst)
        post_done && wr_flag);
endmodule
`default_nettype wire

// file: shared/pts_pkg.sv
// Purpose: constants and types shared by the period timer block
// Assumes: 8-bit register port, one clock
// Notes: register indices are word offsets on the plain register port
package pts_pkg;
    localparam logic [7:0] PTS_OFS_FLAG = 8'h0c;
    localparam logic [7:0] PTS_OFS_COUNT = 8'h11;
    localparam logic [7:0] PTS_OFS_CTRL = 8'h12;
    localparam logic [7:0] PTS_OFS_ENABLE = 8'h8c;
    localparam logic [7:0] PTS_OFS_PERIOD = 8'h92;
    localparam logic [7:0] PTS_RST_COUNT = 8'h00;
    localparam logic [7:0] PTS_RST_PERIOD = 8'hff;
    localparam logic [6:0] PTS_RST_CTRL = 7'h00;
    localparam int PTS_FLAG_BIT = 1;
    localparam int PTS_RUN_BIT = 2;
    localparam logic [1:0] PTS_PRE_DIV1 = 2'h0;
    localparam logic [1:0] PTS_PRE_DIV4 = 2'h1;
    localparam logic [3:0] PTS_PRE_LAST4 = 4'h3;
    localparam logic [3:0] PTS_PRE_LAST16 = 4'hf;
    // instruction clock is the system clock divided by four
    localparam logic [1:0] PTS_ICLK_LAST = 2'h3;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic timer_run;
        logic [1:0] prescale_select;
    } pts_ctrl_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pts_bus_type;

    typedef struct packed {
        logic [7:0] count;
        logic match;
        logic tick;
    } pts_base_type;
endpackage

// file: logic/pts_prescaler.sv
// Purpose: instruction clock divider and selectable prescaler
// Assumes: clear is a one-cycle pulse from the register side
// Notes: emits one-cycle tick per prescaled timer increment
`timescale 1ns/1ns
`default_nettype none
module pts_prescaler
    import pts_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    // output
    output logic tick
);
    logic [1:0] iclk_r;
    logic [3:0] pre_r;
    logic iclk_end;
    logic [3:0] pre_last;

    assign iclk_end = (iclk_r == PTS_ICLK_LAST);

    always_comb begin
        case (sel)
            PTS_PRE_DIV1: pre_last = 4'h0;
            PTS_PRE_DIV4: pre_last = PTS_PRE_LAST4;
            default: pre_last = PTS_PRE_LAST16;
        endcase
    end

    // held while stopped; the control write that restarts counting clears them first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            iclk_r <= 2'h0;
            pre_r <= 4'h0;
        end else if (clear) begin
            iclk_r <= 2'h0;
            pre_r <= 4'h0;
        end else if (run) begin
            iclk_r <= iclk_r + 2'h1;
            if (iclk_end) begin
                pre_r <= (pre_r >= pre_last) ? 4'h0 : pre_r + 4'h1;
            end
        end
    end

    assign tick = run && !clear && iclk_end && (pre_r >= pre_last);

    tick_needs_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick |-> run && $past(iclk_r) == 2'h2)
        else $error("tick without run or off the instruction clock");
    div1_spacing_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && sel == PTS_PRE_DIV1 && $stable(sel) |=> !tick [*3])
        else $error("prescale 1 ticks too often");
endmodule
`default_nettype wire

// file: test/pts_far_model.sv
// Purpose: far side user of the timer match pulse and pwm time base
// Assumes: match is a one-cycle pulse on the system clock
// Notes: counts matches, keeps the count seen at the last match
`timescale 1ns/1ns
`default_nettype none
module pts_far_model
    import pts_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // time base from the timer
    input wire logic ssp_match,
    input wire pts_base_type pwm_base,
    // observations
    output int n_match,
    output logic [7:0] last_cnt
);
    // shift clock source is the unscaled match
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            n_match <= 0;
            last_cnt <= 8'h00;
        end else if (ssp_match) begin
            n_match <= n_match + 1;
            last_cnt <= pwm_base.count;
        end
    end
endmodule
`default_nettype wire

// file: test/pts_tb_top.sv
// Purpose: self-checking bench for the period timer
// Assumes: read data stands one cycle after the read strobe
// Notes: timing is judged by cycles between match pulses
`timescale 1ns/1ns
`default_nettype none
module period_timer_with_pre_post_scaler_tb_top;
    import pts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pts_bus_type bus = '0;
    logic [7:0] rdata, last_cnt, d, c;
    logic irq, ssp_match;
    pts_base_type pwm_base;
    int n_match, gap;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    pts_timer dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
        .irq(irq), .ssp_match(ssp_match), .pwm_base(pwm_base));
    pts_far_model far (.clk_sys(clk_sys), .rst(rst), .ssp_match(ssp_match),
        .pwm_base(pwm_base), .n_match(n_match), .last_cnt(last_cnt));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        @(negedge clk_sys);
        v = rdata;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (ssp_match !== 1'b1 && n < 1000);
        if (ssp_match !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic t_reset();
        logic [7:0] ofs [6];
        logic [7:0] exp [6];
        ofs = '{PTS_OFS_PERIOD, PTS_OFS_COUNT, PTS_OFS_CTRL, PTS_OFS_FLAG,
            PTS_OFS_ENABLE, 8'h13};
        exp = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], d);
            chk(d, exp[i]);
        end
        wr(8'h13, 8'h5a);
        rd(8'h13, d);
        chk(d, 8'h00);
        wr(PTS_OFS_PERIOD, 8'h3c);
        rd(PTS_OFS_PERIOD, d);
        chk(d, 8'h3c);
        wr(PTS_OFS_CTRL, 8'hf8);
        rd(PTS_OFS_CTRL, d);
        chk(d, 8'h78);
        $display("reset and access test done");
    endtask
    task automatic t_prescale();
        int div [4];
        div = '{1, 4, 16, 16};
        wr(PTS_OFS_PERIOD, 8'h02);
        for (int s = 0; s < 4; s++) begin
            wr(PTS_OFS_CTRL, 8'h04 | 8'(s));
            wait_match(gap);
            chk(pwm_base.count, 8'h02);
            chk({7'h0, pwm_base.match}, 8'h01);
            chk({7'h0, pwm_base.tick}, 8'h01);
            wait_match(gap);
            chk(8'(gap), 8'(12 * div[s]));
        end
        chk(last_cnt, 8'h02);
        $display("prescale test done");
    endtask
    task automatic t_postscale();
        int m0;
        for (int p = 0; p < 16; p += 5) begin
            wr(PTS_OFS_CTRL, 8'h00);
            wr(PTS_OFS_FLAG, 8'h02);
            wr(PTS_OFS_ENABLE, 8'h02);
            wr(PTS_OFS_PERIOD, 8'h01);
            wr(PTS_OFS_COUNT, 8'h00);
            m0 = n_match;
            wr(PTS_OFS_CTRL, 8'(p << 3) | 8'h04);
            for (int k = 0; k < 500 && irq !== 1'b1; k++)
                @(negedge clk_sys);
            if (irq !== 1'b1) begin
                n_mismatch++;
                tally_and_finish();
            end
            chk(8'(n_match - m0), 8'(p + 1));
        end
        wr(PTS_OFS_CTRL, 8'h00);
        wr(PTS_OFS_ENABLE, 8'h00);
        rd(PTS_OFS_FLAG, d);
        chk(d, 8'h02);
        chk({7'h0, irq}, 8'h00);
        wr(PTS_OFS_FLAG, 8'h02);
        rd(PTS_OFS_FLAG, d);
        chk(d, 8'h00);
        $display("postscale and flag test done");
    endtask
    task automatic t_stop();
        wr(PTS_OFS_PERIOD, 8'hff);
        wr(PTS_OFS_COUNT, 8'h05);
        rd(PTS_OFS_COUNT, c);
        chk(c, 8'h05);
        wr(PTS_OFS_CTRL, 8'h04);
        repeat (40) @(negedge clk_sys);
        wr(PTS_OFS_CTRL, 8'h00);
        rd(PTS_OFS_COUNT, c);
        chk({7'h0, c > 8'h05}, 8'h01);
        repeat (100) @(negedge clk_sys);
        wr(PTS_OFS_CTRL, 8'h7b);
        rd(PTS_OFS_COUNT, d);
        chk(d, c);
        $display("stop and hold test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_prescale();
        t_postscale();
        t_stop();
        tally_and_finish();
    end
endmodule
`default_nettype wire
